/* exec_regs.svh */
// Offsets, field positions, encodings and reset values of the move/store execution unit.
// Included by the execution module and its bench; definitions only.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// APB byte offsets, one aligned word each
`define ACC_OFS       12'h000
`define BANK_OFS      12'h004
`define PC_HIGH_OFS   12'h008
`define FSR0_OFS      12'h00C
`define FSR1_OFS      12'h010
`define STATUS_OFS    12'h014
`define PWR_STAT_OFS  12'h018
`define EA_OFS        12'h01C
`define CTRL_OFS      12'h020

// Field positions
`define RST_FLAG_BIT  0
`define CTRL_EN_BIT   0

// Reset values
`define ACC_RST       8'h00
`define BANK_RST      6'h00
`define PC_HIGH_RST   7'h00
`define FSR_RST       16'h0000
`define STATUS_RST    8'h18
`define RST_FLAG_RST  1'b1
`define EN_RST        1'b1

// Instruction encodings (14-bit words)
`define LDW_MASK      14'h3F00
`define LDW_VAL       14'h3000
`define LDP_MASK      14'h3F80
`define LDP_VAL       14'h3180
`define LDB_MASK      14'h3FC0
`define LDB_VAL       14'h0140
`define STF_MASK      14'h3F80
`define STF_VAL       14'h0080
`define STI_MASK      14'h3FF8
`define STI_VAL       14'h0018
`define STK_MASK      14'h3F80
`define STK_VAL       14'h3F80
`define RST_VAL       14'h0001
`define IDLE_VAL      14'h0000

// File addresses of the two indirect access ports
`define IND0_ADDR     7'h00
`define IND1_ADDR     7'h01

`endif

/* exec_pkg.sv */
// Types shared by the move/store execution unit.
// Assumes exec_regs.svh holds the numeric constants.
package exec_pkg;

   typedef enum logic [3:0] {
      OP_IDLE, OP_LDB, OP_LDP, OP_LDW, OP_STF, OP_STI, OP_STK, OP_RST, OP_OTHER
   } op_type;

   // Declaration order gives codes 00, 01, 10, 11
   typedef enum logic [1:0] {
      PRE_INC, PRE_DEC, POST_INC, POST_DEC
   } upd_type;

endpackage

/* literal_and_indirect_move_exec.sv */
// Execution of literal loads, accumulator stores, indirect stores and software reset.
// Assumes the decoder presents one instruction word per cycle on pclk; the register
// file sits outside and takes one byte write per cycle on the file port.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "exec_regs.svh"

module literal_and_indirect_move_exec (
   input  wire logic        pclk,             // Core clock, 20 MHz
   input  wire logic        presetn,          // Async reset, active low
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB enable
   input  wire logic        pwrite,           // APB direction
   input  wire logic [11:0] paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   output logic      [31:0] prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error, unmapped
   input  wire logic        instr_valid,      // Instruction word valid
   input  wire logic [13:0] instr_word,       // Instruction word
   output logic             file_we,          // File write strobe
   output logic      [15:0] file_addr,        // File write address
   output logic      [7:0]  file_wdata,       // File write data
   output logic             soft_reset_pulse, // Device reset request
   output logic      [5:0]  bank_out,         // Bank select value
   output logic      [6:0]  pc_high_out,      // PC high latch value
   output logic      [7:0]  acc_out           // Accumulator value
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic exec_pkg::op_type decode(input logic [13:0] w);
      if (w == `IDLE_VAL) begin
         decode = exec_pkg::OP_IDLE;
      end else if (w == `RST_VAL) begin
         decode = exec_pkg::OP_RST;
      end else if ((w & `LDW_MASK) == `LDW_VAL) begin
         decode = exec_pkg::OP_LDW;
      end else if ((w & `LDP_MASK) == `LDP_VAL) begin
         decode = exec_pkg::OP_LDP;
      end else if ((w & `LDB_MASK) == `LDB_VAL) begin
         decode = exec_pkg::OP_LDB;
      end else if ((w & `STF_MASK) == `STF_VAL) begin
         decode = exec_pkg::OP_STF;
      end else if ((w & `STI_MASK) == `STI_VAL) begin
         decode = exec_pkg::OP_STI;
      end else if ((w & `STK_MASK) == `STK_VAL) begin
         decode = exec_pkg::OP_STK;
      end else begin
         decode = exec_pkg::OP_OTHER;
      end
   endfunction

   function automatic logic [15:0] ea_calc(input logic [15:0] p, input logic rel,
                                           input logic [1:0] upd, input logic [5:0] k);
      if (rel) begin
         ea_calc = p + {{10{k[5]}}, k};
      end else if (upd == exec_pkg::PRE_INC) begin
         ea_calc = p + 16'h0001;
      end else if (upd == exec_pkg::PRE_DEC) begin
         ea_calc = p - 16'h0001;
      end else begin
         ea_calc = p;
      end
   endfunction

   function automatic logic [15:0] ptr_next(input logic [15:0] p, input logic rel,
                                            input logic [1:0] upd);
      if (rel) begin
         ptr_next = p;
      end else if (!upd[0]) begin
         ptr_next = p + 16'h0001;
      end else begin
         ptr_next = p - 16'h0001;
      end
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      if (a == `ACC_OFS) begin
         addr_ok = 1'b1;
      end else if (a == `BANK_OFS || a == `PC_HIGH_OFS) begin
         addr_ok = 1'b1;
      end else if (a == `FSR0_OFS || a == `FSR1_OFS) begin
         addr_ok = 1'b1;
      end else if (a == `STATUS_OFS || a == `PWR_STAT_OFS) begin
         addr_ok = 1'b1;
      end else if (a == `EA_OFS || a == `CTRL_OFS) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------
   // State and decode
   // ----------------------------------------------------------------
   logic [7:0]       acc_ff;
   logic [5:0]       bank_ff;
   logic [6:0]       pc_high_ff;
   logic [15:0]      fsr_ff [0:1];
   logic [7:0]       status_ff;
   logic             rst_flag_ff;
   logic             en_ff;
   logic [15:0]      ea_ff;
   logic             soft_rst_ff;
   logic             file_we_ff;
   logic [15:0]      file_addr_ff;
   logic [7:0]       file_wdata_ff;
   logic [31:0]      prdata_ff;
   logic [31:0]      nxt_prdata;
   exec_pkg::op_type op;
   logic             exec;
   logic             is_ind;
   logic             rel;
   logic             ptr_sel;
   logic [15:0]      fsr_sel;
   logic [15:0]      ind_ea;
   logic [6:0]       f_addr;
   logic             apb_wr;
   logic             apb_setup;

   assign op      = decode(instr_word);
   // The cycle that carries out a reset swallows any instruction beside it
   assign exec    = instr_valid && en_ff && !soft_rst_ff;
   assign rel     = (op == exec_pkg::OP_STK);
   assign is_ind  = rel || (op == exec_pkg::OP_STI);
   assign ptr_sel = rel ? instr_word[6] : instr_word[2];
   assign fsr_sel = fsr_ff[ptr_sel];
   assign f_addr  = instr_word[6:0];
   assign ind_ea  = ea_calc(fsr_sel, rel, instr_word[1:0], instr_word[5:0]);

   assign apb_wr    = psel && penable && pwrite && addr_ok(paddr);
   assign apb_setup = psel && !penable;

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   // Instruction writes win over an APB write in the same cycle
   // literal to accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= `ACC_RST;
      end else if (soft_rst_ff) begin
         acc_ff <= `ACC_RST;
      end else if (exec && op == exec_pkg::OP_LDW) begin
         acc_ff <= instr_word[7:0];
      end else if (apb_wr && paddr == `ACC_OFS) begin
         acc_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_ff <= `BANK_RST;
      end else if (soft_rst_ff) begin
         bank_ff <= `BANK_RST;
      end else if (exec && op == exec_pkg::OP_LDB) begin
         bank_ff <= instr_word[5:0];
      end else if (apb_wr && paddr == `BANK_OFS) begin
         bank_ff <= pwdata[5:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_high_ff <= `PC_HIGH_RST;
      end else if (soft_rst_ff) begin
         pc_high_ff <= `PC_HIGH_RST;
      end else if (exec && op == exec_pkg::OP_LDP) begin
         pc_high_ff <= instr_word[6:0];
      end else if (apb_wr && paddr == `PC_HIGH_OFS) begin
         pc_high_ff <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsr_ff[0] <= `FSR_RST;
         fsr_ff[1] <= `FSR_RST;
      end else if (soft_rst_ff) begin
         fsr_ff[0] <= `FSR_RST;
         fsr_ff[1] <= `FSR_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (exec && is_ind && !rel && ptr_sel == i[0]) begin
               fsr_ff[i] <= ptr_next(fsr_ff[i], rel, instr_word[1:0]);
            end else if (apb_wr && paddr == (i == 0 ? `FSR0_OFS : `FSR1_OFS)) begin
               fsr_ff[i] <= pwdata[15:0];
            end
         end
      end
   end

   // flags change only by an APB write or the software reset, never by the other instructions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= `STATUS_RST;
      end else if (soft_rst_ff) begin
         status_ff <= `STATUS_RST;
      end else if (apb_wr && paddr == `STATUS_OFS) begin
         status_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ff <= `EN_RST;
      end else if (soft_rst_ff) begin
         en_ff <= `EN_RST;
      end else if (apb_wr && paddr == `CTRL_OFS) begin
         en_ff <= pwdata[`CTRL_EN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Software reset
   // ----------------------------------------------------------------
   // reset request, one cycle long
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= exec && op == exec_pkg::OP_RST;
      end
   end

   // Flag survives the software reset so software can see its cause;
   // the hardware clear wins over a software write in the same cycle
   // reset cause flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_flag_ff <= `RST_FLAG_RST;
      end else if (exec && op == exec_pkg::OP_RST) begin
         rst_flag_ff <= 1'b0;
      end else if (apb_wr && paddr == `PWR_STAT_OFS) begin
         rst_flag_ff <= pwdata[`RST_FLAG_BIT];
      end
   end

   // ----------------------------------------------------------------
   // File write port
   // ----------------------------------------------------------------
   // store in one cycle, port redirected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_we_ff    <= 1'b0;
         file_addr_ff  <= 16'h0000;
         file_wdata_ff <= 8'h00;
         ea_ff         <= 16'h0000;
      end else begin
         file_we_ff <= exec && (is_ind || op == exec_pkg::OP_STF);
         if (exec && is_ind) begin
            file_addr_ff  <= ind_ea;
            file_wdata_ff <= acc_ff;
            ea_ff         <= ind_ea;
         end else if (exec && op == exec_pkg::OP_STF) begin
            file_wdata_ff <= acc_ff;
            if (f_addr == `IND0_ADDR || f_addr == `IND1_ADDR) begin
               file_addr_ff <= fsr_ff[f_addr[0]];
               ea_ff        <= fsr_ff[f_addr[0]];
            end else begin
               file_addr_ff <= {3'h0, bank_ff, f_addr};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Read data is sampled in the setup cycle; zero wait states
   always_comb begin
      nxt_prdata = 32'h00000000;
      if (paddr == `ACC_OFS) begin
         nxt_prdata[7:0] = acc_ff;
      end else if (paddr == `BANK_OFS) begin
         nxt_prdata[5:0] = bank_ff;
      end else if (paddr == `PC_HIGH_OFS) begin
         nxt_prdata[6:0] = pc_high_ff;
      end else if (paddr == `FSR0_OFS) begin
         nxt_prdata[15:0] = fsr_ff[0];
      end else if (paddr == `FSR1_OFS) begin
         nxt_prdata[15:0] = fsr_ff[1];
      end else if (paddr == `STATUS_OFS) begin
         nxt_prdata[7:0] = status_ff;
      end else if (paddr == `PWR_STAT_OFS) begin
         nxt_prdata[`RST_FLAG_BIT] = rst_flag_ff;
      end else if (paddr == `EA_OFS) begin
         nxt_prdata[15:0] = ea_ff;
      end else if (paddr == `CTRL_OFS) begin
         nxt_prdata[`CTRL_EN_BIT] = en_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else if (apb_setup && !pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata           = prdata_ff;
   assign pready           = 1'b1;
   assign pslverr          = psel && penable && !addr_ok(paddr);
   assign file_we          = file_we_ff;
   assign file_addr        = file_addr_ff;
   assign file_wdata       = file_wdata_ff;
   assign soft_reset_pulse = soft_rst_ff;
   assign bank_out         = bank_ff;
   assign pc_high_out      = pc_high_ff;
   assign acc_out          = acc_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_LDB: assert property (exec && op == exec_pkg::OP_LDB
      |=> bank_out == $past(instr_word[5:0])) else $error("bank load wrong");
   AST_LDP: assert property (exec && op == exec_pkg::OP_LDP
      |=> pc_high_out == $past(instr_word[6:0]) && $stable(status_ff))
      else $error("pc high load wrong");
   AST_LDW: assert property (exec && op == exec_pkg::OP_LDW
      |=> acc_out == $past(instr_word[7:0])) else $error("literal load wrong");
   AST_STF: assert property (exec && op == exec_pkg::OP_STF && f_addr > 7'h01
      |=> file_we && file_wdata == $past(acc_ff)
          && file_addr == {3'h0, $past(bank_ff), $past(f_addr)})
      else $error("file store wrong");
   AST_PREINC: assert property (exec && op == exec_pkg::OP_STI
      && instr_word[1:0] == 2'b00 |=> file_addr == $past(fsr_sel) + 16'h0001)
      else $error("pre-increment address wrong");
   AST_POSTDEC: assert property (exec && op == exec_pkg::OP_STI
      && instr_word[1:0] == 2'b11 && !apb_wr
      |=> file_addr == $past(fsr_sel) && fsr_ff[$past(ptr_sel)] == $past(fsr_sel) - 16'h0001)
      else $error("post-decrement wrong");
   AST_REL: assert property (exec && rel && !apb_wr
      |=> file_addr == $past(fsr_sel) + {{10{$past(instr_word[5])}}, $past(instr_word[5:0])}
          ##0 $stable(fsr_ff[0]) && $stable(fsr_ff[1]))
      else $error("relative store wrong");
   AST_WRAP: assert property (exec && op == exec_pkg::OP_STI
      && instr_word[1:0] == 2'b10 && fsr_sel == 16'hFFFF && !apb_wr
      |=> fsr_ff[$past(ptr_sel)] == 16'h0000) else $error("pointer did not wrap");
   AST_IND: assert property (exec && op == exec_pkg::OP_STF && f_addr == `IND1_ADDR
      |=> file_addr == $past(fsr_ff[1])) else $error("indirect port not redirected");
   AST_FLAGS: assert property ($changed(status_ff)
      |-> $past(apb_wr && paddr == `STATUS_OFS) || $past(soft_rst_ff))
      else $error("flags changed by instruction");
   AST_RST: assert property (exec && op == exec_pkg::OP_RST
      |=> soft_reset_pulse && !rst_flag_ff ##1 !soft_reset_pulse && acc_out == `ACC_RST
          && fsr_ff[0] == `FSR_RST) else $error("software reset wrong");
   AST_ONE: assert property (file_we
      |-> $past(exec && (is_ind || op == exec_pkg::OP_STF))) else $error("stray file write");

   COV_LDW:  cover property (exec && op == exec_pkg::OP_LDW ##1 exec && op == exec_pkg::OP_STF);
   COV_REL:  cover property (exec && rel && instr_word[5]);
   COV_WRAP: cover property (exec && op == exec_pkg::OP_STI && fsr_sel == 16'h0000
                             && instr_word[1:0] == 2'b01);
   COV_RST:  cover property (exec && op == exec_pkg::OP_RST ##2 apb_wr && paddr == `PWR_STAT_OFS);

endmodule

/* literal_and_indirect_move_exec_tb.sv */
// Self-checking bench for the move/store execution unit.
// Assumes the unit answers APB with zero wait states and takes one instruction per cycle.
`timescale 1ns/1ps
`include "exec_regs.svh"
`define CHECK(what, exp, act) begin cmp_count++; if ((act) !== (exp)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", what, exp, act); end end

module literal_and_indirect_move_exec_tb;
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic        instr_valid = 1'b0;
   logic [13:0] instr_word  = 14'h0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        file_we;
   logic [15:0] file_addr;
   logic [7:0]  file_wdata;
   logic        soft_reset_pulse;
   logic [5:0]  bank_out;
   logic [6:0]  pc_high_out;
   logic [7:0]  acc_out;
   int          fails       = 0;
   int          cmp_count   = 0;
   logic [31:0] rd;
   logic        err;

   literal_and_indirect_move_exec i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
      .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
      .soft_reset_pulse(soft_reset_pulse), .bank_out(bank_out), .pc_high_out(pc_high_out),
      .acc_out(acc_out)
   );

   always #25 pclk = ~pclk;

   // ---------------------------------------------
   // Bus and instruction drivers
   // ---------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic read_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHECK(nm, e, rd)
   endtask

   // Outputs of an instruction land at the edge that takes it
   task automatic ins(input logic [13:0] w);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge pclk);
      instr_valid <= 1'b0;
      instr_word <= `IDLE_VAL;
      #1;
   endtask

   task automatic exp_store(input string nm, input logic [15:0] ea, input logic [7:0] d);
      `CHECK(nm, 1'b1, file_we)
      `CHECK(nm, ea, file_addr)
      `CHECK(nm, d, file_wdata)
      @(posedge pclk);
      #1;
      `CHECK(nm, 1'b0, file_we)
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #(50 * 20000);
      fails++;
      final_report();
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      logic [15:0] st, nw, ea;
      logic [1:0]  upd;
      logic [5:0]  k;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      read_chk("acc rst", `ACC_OFS, 32'h0000_0000);
      read_chk("bank rst", `BANK_OFS, 32'h0000_0000);
      read_chk("pc high rst", `PC_HIGH_OFS, 32'h0000_0000);
      read_chk("fsr0 rst", `FSR0_OFS, 32'h0000_0000);
      read_chk("fsr1 rst", `FSR1_OFS, 32'h0000_0000);
      read_chk("status rst", `STATUS_OFS, 32'h0000_0018);
      read_chk("flag rst", `PWR_STAT_OFS, 32'h0000_0001);
      `CHECK("pready", 1'b1, pready)
      read_chk("ctrl rst", `CTRL_OFS, 32'h0000_0001);
      `CHECK("mapped err", 1'b0, err)
      read_chk("unmapped", 12'h0FC, 32'h0000_0000);
      `CHECK("unmapped err", 1'b1, err)
      apb(1'b1, `FSR0_OFS, 32'hFFFF_ABCD);
      read_chk("fsr0 width", `FSR0_OFS, 32'h0000_ABCD);
      $display("test reset and registers done");

      ins(`LDW_VAL | 14'h00FF);
      `CHECK("ldw max", 8'hFF, acc_out)
      ins(`LDW_VAL | 14'h003C);
      `CHECK("ldw", 8'h3C, acc_out)
      ins(`LDB_VAL | 14'h003F);
      `CHECK("ldb", 6'h3F, bank_out)
      ins(`LDP_VAL | 14'h007F);
      `CHECK("ldp", 7'h7F, pc_high_out)
      ins(`STF_VAL | 14'h007F);
      exp_store("stf", 16'h1FFF, 8'h3C);
      read_chk("status lit", `STATUS_OFS, 32'h0000_0018);
      $display("test literal loads done");

      apb(1'b1, `FSR0_OFS, 32'h0000_0100);
      apb(1'b1, `FSR1_OFS, 32'h0000_8001);
      ins(`STF_VAL | 14'h0000);
      exp_store("ind0", 16'h0100, 8'h3C);
      ins(`STF_VAL | 14'h0001);
      exp_store("ind1", 16'h8001, 8'h3C);
      $display("test indirect port done");

      for (int s = 0; s < 2; s++) begin
         for (int m = 0; m < 4; m++) begin
            st = (s == 0) ? 16'hFFFF : 16'h0000;
            upd = m[1:0];
            nw = st + (upd[0] ? 16'hFFFF : 16'h0001);
            ea = upd[1] ? st : nw;
            apb(1'b1, `FSR1_OFS, {16'h0000, st});
            ins(`STI_VAL | {11'h000, 1'b1, upd});
            exp_store("sti", ea, 8'h3C);
            read_chk("sti ptr", `FSR1_OFS, {16'h0000, nw});
            read_chk("sti ea", `EA_OFS, {16'h0000, ea});
         end
      end
      read_chk("status sti", `STATUS_OFS, 32'h0000_0018);
      $display("test pointer update modes done");

      for (int j = 0; j < 2; j++) begin
         k = (j == 0) ? 6'h20 : 6'h1F;
         ins(`STK_VAL | {7'h00, 1'b0, k});
         exp_store("rel", 16'h0100 + {{10{k[5]}}, k}, 8'h3C);
         read_chk("rel ptr", `FSR0_OFS, 32'h0000_0100);
      end
      apb(1'b1, `EA_OFS, 32'h0000_5555);
      read_chk("ea ro", `EA_OFS, 32'h0000_011F);
      $display("test relative offset done");

      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= `STI_VAL | 14'h0002;
      @(posedge pclk);
      #1;
      `CHECK("b2b one", 16'h0100, file_addr)
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
      `CHECK("b2b we", 1'b1, file_we)
      `CHECK("b2b two", 16'h0101, file_addr)
      $display("test back to back done");

      apb(1'b1, `CTRL_OFS, 32'h0000_0000);
      ins(`LDW_VAL | 14'h0055);
      `CHECK("disabled", 8'h3C, acc_out)
      apb(1'b1, `CTRL_OFS, 32'h0000_0001);
      // Undecoded word must leave the accumulator and the file port alone
      ins(14'h2000);
      `CHECK("unknown we", 1'b0, file_we)
      `CHECK("unknown acc", 8'h3C, acc_out)
      $display("test execute enable done");

      ins(`RST_VAL);
      `CHECK("srst pulse", 1'b1, soft_reset_pulse)
      @(posedge pclk);
      #1;
      `CHECK("srst end", 1'b0, soft_reset_pulse)
      `CHECK("srst acc", 8'h00, acc_out)
      `CHECK("srst bank", 6'h00, bank_out)
      `CHECK("srst pc high", 7'h00, pc_high_out)
      read_chk("srst flag", `PWR_STAT_OFS, 32'h0000_0000);
      read_chk("srst fsr0", `FSR0_OFS, 32'h0000_0000);
      $display("test software reset done");
      final_report();
   end
endmodule
